// [test/isc_channel_sva.sv]
// Checker for the audio channel: bus handshake, reserved read bits, serial output timing.
// Assumes it is bound to isc_channel and sees only its ports.
`timescale 1ns/1ps
module isc_channel_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic sck,
    input wire logic sd_out
);
    wire logic rd = psel && penable && pready && !pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err; pslverr |-> pready && psel && penable; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_rx_res; rd && paddr == 8'h30 |-> prdata[31:3] == 29'h0; endproperty
    a_rx_res: assert property (p_rx_res) else $error("rx res bits");
    property p_tx_res; rd && paddr == 8'h34 |-> prdata[31:3] == 29'h0; endproperty
    a_tx_res: assert property (p_tx_res) else $error("tx res bits");
    property p_flag; rd && paddr[7:3] == 5'h07 |-> !prdata[31:6] && !prdata[3:2]; endproperty
    a_flag: assert property (p_flag) else $error("flag bits");
    property p_clr; rd && paddr[7:4] == 4'h4 |-> prdata[31:1] == 31'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear bits");
    property p_sd; $changed(sd_out) |-> !sck; endproperty
    a_sd: assert property (p_sd) else $error("sd edge");
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
    c_clr: cover property (rd && paddr == 8'h40 && prdata[0]);
endmodule

bind isc_channel isc_channel_sva isc_channel_sva_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .irq, .sck, .sd_out);

// [test/isc_codec_model.sv]
// Serial audio partner: makes bit clock and word select, sends and captures words.
// Assumes the channel samples on bit clock rises; the clock stands still between frames.
`timescale 1ns/1ps
module isc_codec_model (
    output logic sck,
    output logic ws,
    output logic sd,
    input wire logic sd_dev
);
    logic started = 1'b0;
    logic [31:0] got_l;
    logic [31:0] got_r;
    initial begin
        sck = 1'b0;
        ws = 1'b1;
        sd = 1'b0;
    end
    // One left and right word of n bits; the closing word select fall commits the pair.
    task automatic frame(input logic [31:0] l, input logic [31:0] r, input int n);
        #7;
        for (int j = started ? 1 : 0; j <= 2 * n; j++) begin
            ws = (j >= n) && (j < 2 * n);
            sd = (j == 0) ? !sd : (j <= n) ? l[n - j] : r[2 * n - j];
            #100 sck = 1'b1;
            #100;
            if (j > 0 && j <= n) begin
                got_l = {got_l[30:0], sd_dev};
            end else if (j > n) begin
                got_r = {got_r[30:0], sd_dev};
            end
            sck = 1'b0;
        end
        started = 1'b1;
        sd = !sd;
    endtask
endmodule

// [test/tb_top.sv]
// Testbench for the audio channel: bus accesses, interrupts and serial frames.
// Assumes the checker is bound and the partner model drives the serial side.
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdata, m;
    logic pready, pslverr, irq, sck, ws, sd_in, sd_out, err;
    int miscompares = 0;
    int samples_checked = 0;
    int lens [6] = '{32, 12, 16, 20, 24, 32};
    logic [31:0] tl = 32'ha5c3_96e1;
    logic [31:0] tr = 32'h5a3c_691e;
    logic [31:0] rl = 32'hc0de_7b2d;
    logic [31:0] rr = 32'h3e91_d4a7;
    always #12.5 pclk = ~pclk;
    isc_channel isc_channel_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .sck, .ws, .sd_in, .sd_out);
    isc_codec_model isc_codec_model_inst (.sck, .ws, .sd(sd_in), .sd_dev(sd_out));
    task check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] want);
        xfer(1'b0, a, 32'h0000_0000);
        check(rdata, want);
    endtask
    task ck_irq(input logic want);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, {31'h0, want});
    endtask
    task results();
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        miscompares++;
        results();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h38, 32'h0000_0010);
        rd(8'h3c, 32'h0000_0033);
        rd(8'h30, 32'h0000_0002);
        rd(8'h34, 32'h0000_0002);
        ck_irq(1'b0);
        wr(8'h3c, 32'hffff_ffef);
        rd(8'h3c, 32'h0000_0023);
        ck_irq(1'b1);
        rd(8'h50, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        wr(8'h20, tl);
        wr(8'h24, tr);
        wr(8'h20, tl);
        ck_irq(1'b0);
        rd(8'h38, 32'h0000_0020);
        wr(8'h3c, 32'h0000_0013);
        ck_irq(1'b1);
        rd(8'h44, 32'h0000_0001);
        ck_irq(1'b0);
        wr(8'h3c, 32'h0000_0032);
        isc_codec_model_inst.frame(32'h0000_0000, 32'h0000_0000, 16);
        for (int c = 0; c < 6; c++) begin
            m = (lens[c] == 32) ? 32'hffff_ffff : (32'h0000_0001 << lens[c]) - 32'h0000_0001;
            wr(8'h30, 32'(c));
            wr(8'h34, 32'(c));
            wr(8'h20, tl);
            wr(8'h24, tr);
            repeat (2) isc_codec_model_inst.frame(rl, rr, lens[c]);
            check(isc_codec_model_inst.got_l & m, tl & m);
            check(isc_codec_model_inst.got_r & m, tr & m);
            ck_irq(1'b1);
            rd(8'h38, 32'h0000_0013);
            rd(8'h20, rl & m);
            rd(8'h24, rr & m);
            rd(8'h40, 32'h0000_0001);
            rd(8'h38, 32'h0000_0010);
        end
        results();
    end
endmodule

// [verilog/isc_channel.sv]
// One stereo serial audio channel with its word length, buffer and interrupt logic.
// Assumes an APB master on pclk and an external partner driving bit clock and word select.
//
// Functional notes
// - Receive resolution field selects received word length.
// - Received samples are right aligned in buffers.
// - Transmit resolution field selects transmitted word length.
// - Samples are shifted out most significant first.
// - Transmit overrun status bit five, reset zero.
// - Transmit empty trigger bit four, reset one.
// - Receive overrun status bit one, reset zero.
// - Receive data available bit zero, reset zero.
// - Mask bits five, four, one reset masked.
// - Mask bit zero gates data available, reset one.
// - Reading receive overrun clear register clears it.
// - Reading transmit overrun clear register clears it.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "isc_params.svh"

module isc_channel
    import isc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic sck,
    input wire logic ws,
    input wire logic sd_in,
    output logic sd_out
);

    isc_state_t st;
    isc_state_t next_st;

    // Word length in bits for a resolution code; zero means no length applies.
    function automatic logic [5:0] isc_len(input logic [2:0] res);
        unique case (res)
            `ISC_RES_12: isc_len = 6'd12;
            `ISC_RES_16: isc_len = 6'd16;
            `ISC_RES_20: isc_len = 6'd20;
            `ISC_RES_24: isc_len = 6'd24;
            `ISC_RES_32: isc_len = 6'd32;
            default: isc_len = 6'd0;
        endcase
    endfunction

    // Keeps the first bits of a word and places its last kept bit at bit zero.
    function automatic logic [31:0] isc_rx_align(input logic [31:0] sh, input logic [5:0] n,
                                                 input logic [2:0] res);
        logic [5:0] len;
        len = isc_len(res);
        isc_rx_align = sh;
        if (len != 6'd0 && n > len) begin
            isc_rx_align = sh >> (n - len);
        end
    endfunction

    // Moves the top bit of a sample of the selected length to bit 31.
    function automatic logic [31:0] isc_tx_align(input logic [31:0] d, input logic [2:0] res);
        logic [5:0] len;
        len = isc_len(res);
        if (len == 6'd0) begin
            len = `ISC_MAX_BITS;
        end
        isc_tx_align = d << (`ISC_MAX_BITS - len);
    endfunction

    // True for every offset that the register map decodes.
    function automatic logic isc_mapped(input logic [7:0] a);
        unique case (a)
            `ISC_OFF_LEFT_BUF,
            `ISC_OFF_RIGHT_BUF,
            `ISC_OFF_RX_RES,
            `ISC_OFF_TX_RES,
            `ISC_OFF_FLAGS,
            `ISC_OFF_MASKS,
            `ISC_OFF_RX_OVR_CLR,
            `ISC_OFF_TX_OVR_CLR: begin
                isc_mapped = 1'b1;
            end
            default: begin
                isc_mapped = 1'b0;
            end
        endcase
    endfunction

    // Read value of one register offset; unmapped offsets read zero.
    function automatic logic [31:0] isc_read_word(input logic [7:0] a, input isc_state_t s,
                                                  input logic [31:0] fl,
                                                  input logic [31:0] mk);
        isc_read_word = 32'h0000_0000;
        unique case (a)
            `ISC_OFF_LEFT_BUF: begin
                isc_read_word = s.rx_left;
            end
            `ISC_OFF_RIGHT_BUF: begin
                isc_read_word = s.rx_right;
            end
            `ISC_OFF_RX_RES: begin
                isc_read_word = {29'h0, s.rx_res};
            end
            `ISC_OFF_TX_RES: begin
                isc_read_word = {29'h0, s.tx_res};
            end
            `ISC_OFF_FLAGS: begin
                isc_read_word = fl;
            end
            `ISC_OFF_MASKS: begin
                isc_read_word = mk;
            end
            `ISC_OFF_RX_OVR_CLR: begin
                isc_read_word = {31'h0, s.rx_ovr};
            end
            `ISC_OFF_TX_OVR_CLR: begin
                isc_read_word = {31'h0, s.tx_ovr};
            end
            default: begin
                isc_read_word = 32'h0000_0000;
            end
        endcase
    endfunction

    logic [31:0] flags;
    logic [31:0] masks;
    logic done;
    logic rise;
    logic fall;
    logic [31:0] sh_in;
    logic [31:0] word;
    logic [5:0] cnt_in;

    always_comb begin
        flags = 32'h0000_0000;
        flags[`ISC_BIT_TX_OVR] = st.tx_ovr;
        flags[`ISC_BIT_TX_EMPTY] = ~st.tx_full;
        flags[`ISC_BIT_RX_OVR] = st.rx_ovr;
        flags[`ISC_BIT_RX_AVAIL] = st.rx_avail;
        masks = 32'h0000_0000;
        masks[`ISC_BIT_TX_OVR] = st.mask[3];
        masks[`ISC_BIT_TX_EMPTY] = st.mask[2];
        masks[`ISC_BIT_RX_OVR] = st.mask[1];
        masks[`ISC_BIT_RX_AVAIL] = st.mask[0];
    end

    always_comb begin
        next_st = st;
        done = psel & penable & st.pready;
        rise = st.sync2.sck & ~st.sck_prev;
        fall = ~st.sync2.sck & st.sck_prev;
        sh_in = {st.rx_shift[30:0], st.sync2.sd};
        cnt_in = (st.rx_cnt < `ISC_MAX_BITS) ? st.rx_cnt + 6'd1 : `ISC_MAX_BITS;
        word = isc_rx_align(sh_in, cnt_in, st.rx_res);

        next_st.sync1 = '{sck: sck, ws: ws, sd: sd_in};
        next_st.sync2 = st.sync1;
        next_st.sck_prev = st.sync2.sck;

        // Bus side: answer after one wait state, act on the completing edge.
        next_st.pready = psel & penable & ~st.pready;
        next_st.pslverr = 1'b0;
        if (psel & penable & ~st.pready) begin
            next_st.prdata = isc_read_word(paddr, st, flags, masks);
            next_st.pslverr = ~isc_mapped(paddr);
        end
        if (done & pwrite) begin
            unique case (paddr)
                `ISC_OFF_LEFT_BUF: begin
                    if (st.tx_full) begin
                        next_st.tx_ovr = 1'b1;
                    end else begin
                        next_st.tx_left = pwdata;
                    end
                end
                `ISC_OFF_RIGHT_BUF: begin
                    if (st.tx_full) begin
                        next_st.tx_ovr = 1'b1;
                    end else begin
                        next_st.tx_right = pwdata;
                        next_st.tx_full = 1'b1;
                    end
                end
                `ISC_OFF_RX_RES: next_st.rx_res = pwdata[2:0];
                `ISC_OFF_TX_RES: next_st.tx_res = pwdata[2:0];
                `ISC_OFF_FLAGS: begin
                    if (pwdata[`ISC_BIT_TX_OVR]) begin
                        next_st.tx_ovr = 1'b0;
                    end
                    if (pwdata[`ISC_BIT_RX_OVR]) begin
                        next_st.rx_ovr = 1'b0;
                    end
                end
                `ISC_OFF_MASKS: begin
                    next_st.mask = {pwdata[`ISC_BIT_TX_OVR], pwdata[`ISC_BIT_TX_EMPTY],
                                    pwdata[`ISC_BIT_RX_OVR], pwdata[`ISC_BIT_RX_AVAIL]};
                end
                default: next_st.mask = st.mask;
            endcase
        end
        if (done & ~pwrite) begin
            unique case (paddr)
                `ISC_OFF_RIGHT_BUF: next_st.rx_avail = 1'b0;
                `ISC_OFF_RX_OVR_CLR: next_st.rx_ovr = 1'b0;
                `ISC_OFF_TX_OVR_CLR: next_st.tx_ovr = 1'b0;
                default: next_st.rx_avail = st.rx_avail;
            endcase
        end

        // Serial side: sample on bit clock rise, drive on its fall.
        if (rise) begin
            next_st.rx_shift = sh_in;
            next_st.rx_cnt = cnt_in;
            next_st.ws_last = st.sync2.ws;
            if (st.sync2.ws != st.ws_last) begin
                next_st.rx_shift = 32'h0000_0000;
                next_st.rx_cnt = 6'd0;
                if (!st.ws_last) begin
                    next_st.rx_left_pend = word;
                end else begin
                    next_st.rx_left = st.rx_left_pend;
                    next_st.rx_right = word;
                    if (next_st.rx_avail) begin
                        next_st.rx_ovr = 1'b1;
                    end
                    next_st.rx_avail = 1'b1;
                end
                if (!st.sync2.ws) begin
                    next_st.tx_shift = 32'h0000_0000;
                    if (next_st.tx_full) begin
                        next_st.tx_shift = isc_tx_align(next_st.tx_left, st.tx_res);
                        next_st.tx_right_cur = next_st.tx_right;
                        next_st.tx_full = 1'b0;
                    end else begin
                        next_st.tx_right_cur = 32'h0000_0000;
                    end
                end else begin
                    next_st.tx_shift = isc_tx_align(st.tx_right_cur, st.tx_res);
                end
            end
        end
        if (fall) begin
            next_st.sd_out = st.tx_shift[31];
            next_st.tx_shift = {st.tx_shift[30:0], 1'b0};
        end

        next_st.irq = |(flags & ~masks);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.rx_res <= `ISC_RES_RESET;
            st.tx_res <= `ISC_RES_RESET;
            st.mask <= `ISC_MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq = st.irq;
    assign sd_out = st.sd_out;

endmodule

// [verilog/isc_params.svh]
// Register offsets, field positions, reset values and limits of the audio channel.
// Included by the channel module; holds definitions only.
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH

`define ISC_OFF_LEFT_BUF 8'h20
`define ISC_OFF_RIGHT_BUF 8'h24
`define ISC_OFF_RX_RES 8'h30
`define ISC_OFF_TX_RES 8'h34
`define ISC_OFF_FLAGS 8'h38
`define ISC_OFF_MASKS 8'h3c
`define ISC_OFF_RX_OVR_CLR 8'h40
`define ISC_OFF_TX_OVR_CLR 8'h44

`define ISC_BIT_TX_OVR 5
`define ISC_BIT_TX_EMPTY 4
`define ISC_BIT_RX_OVR 1
`define ISC_BIT_RX_AVAIL 0

`define ISC_RES_RESET 3'h2
`define ISC_MASK_RESET 4'hf

`define ISC_RES_IGNORE 3'h0
`define ISC_RES_12 3'h1
`define ISC_RES_16 3'h2
`define ISC_RES_20 3'h3
`define ISC_RES_24 3'h4
`define ISC_RES_32 3'h5

`define ISC_MAX_BITS 6'h20

`endif

// [verilog/isc_pkg.sv]
// Types shared by the audio channel: its whole state as one packed struct.
// Assumes isc_params.svh is on the include path.
package isc_pkg;
    typedef struct packed {
        logic sck;
        logic ws;
        logic sd;
    } isc_pins_t;

    typedef struct packed {
        isc_pins_t sync1;
        isc_pins_t sync2;
        logic sck_prev;
        logic ws_last;
        logic [2:0] rx_res;
        logic [2:0] tx_res;
        logic [3:0] mask;
        logic tx_ovr;
        logic rx_ovr;
        logic rx_avail;
        logic tx_full;
        logic [31:0] rx_left;
        logic [31:0] rx_right;
        logic [31:0] rx_left_pend;
        logic [31:0] rx_shift;
        logic [5:0] rx_cnt;
        logic [31:0] tx_left;
        logic [31:0] tx_right;
        logic [31:0] tx_right_cur;
        logic [31:0] tx_shift;
        logic sd_out;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } isc_state_t;
endpackage
